// *** uart_flow_fifo_config_regs_tb.sv ***
// Self-checking bench of the UART configuration registers.
// Assumes ufcr_top and the host model ufcr_host.
`default_nettype none
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin failures++; \
   $display("[FAIL] t=%0t act=%h exp=%h", $time, (act), (exp)); end end

module uart_flow_fifo_config_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic cs_n, wr_n, rd_n;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, rx_fill = 8'h00, tx_free = 8'h00, rx_char = 8'h00, d;
   logic rx_timeout = 1'b0, rx_char_valid = 1'b0, tx_pending = 1'b1, cts_n = 1'b0;
   logic rts_n, dtr_n, tx_halt, special_match, oversample_by8, tx_ready, rx_ready;
   logic [3:0] sw_flow_sel;
   logic [15:0] divisor;
   logic [5:0] divisor_frac;
   logic [7:0] tx_trigger, rx_trigger;
   int failures = 0;
   int checks = 0;

   // ****************************************
   // Instances
   // ****************************************
   ufcr_host i_host (.clk(clk_sys), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .wdata(wdata),
      .rdata(rdata));
   ufcr_top i_dut (.CLK_SYS(clk_sys), .RESETN(resetn), .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n), .ADDR(addr),
      .WDATA(wdata), .RDATA(rdata), .RX_FILL(rx_fill), .TX_FREE(tx_free), .RX_TIMEOUT(rx_timeout),
      .RX_CHAR_VALID(rx_char_valid), .RX_CHAR(rx_char), .TX_PENDING(tx_pending), .CTS_N(cts_n),
      .RTS_N(rts_n), .DTR_N(dtr_n), .TX_HALT(tx_halt), .SPECIAL_MATCH(special_match),
      .SW_FLOW_SEL(sw_flow_sel), .DIVISOR(divisor), .DIVISOR_FRAC(divisor_frac),
      .OVERSAMPLE_BY8(oversample_by8), .TX_TRIGGER(tx_trigger), .RX_TRIGGER(rx_trigger),
      .TX_READY(tx_ready), .RX_READY(rx_ready));

   always #10 clk_sys = ~clk_sys;

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys) #1;
   endtask

   task automatic t_reset;
      `CHK({rts_n, dtr_n, oversample_by8, divisor}, 19'h60000)
      `CHK({tx_trigger, rx_trigger}, 16'h0808)
   endtask

   task automatic t_gate;
      i_host.wr(3'h3, 8'h00);
      i_host.wr(3'h4, 8'hE0);
      // Fifo control bits 5:4 stay closed, receive select 3 lands
      i_host.wr(3'h2, 8'hF1);
      i_host.wr(3'h7, 8'h32);
      i_host.rd(3'h4, d);
      `CHK(d, 8'h00)
      `CHK({tx_trigger, rx_trigger}, 16'h083C)
   endtask

   task automatic t_div;
      i_host.wr(3'h3, 8'hBF);
      i_host.wr(3'h2, 8'h15);
      // Divisors written while sleep is still off
      i_host.wr(3'h3, 8'h80);
      i_host.wr(3'h0, 8'h34);
      i_host.wr(3'h1, 8'h12);
      i_host.wr(3'h4, 8'h85);
      cyc(2);
      `CHK(sw_flow_sel, 4'h5)
      `CHK(divisor, 16'h1234)
      `CHK({oversample_by8, divisor_frac}, 7'h45)
   endtask

   task automatic t_thr;
      i_host.wr(3'h3, 8'h00);
      i_host.wr(3'h4, 8'h44);
      i_host.wr(3'h6, 8'h24);
      i_host.wr(3'h7, 8'h32);
      cyc(2);
      `CHK({tx_trigger, rx_trigger}, 16'h1018)
      i_host.rd(3'h6, d);
      `CHK(d, 8'h24)
   endtask

   task automatic t_flow;
      i_host.wr(3'h3, 8'hBF);
      i_host.wr(3'h2, 8'hD5);
      i_host.wr(3'h3, 8'h00);
      rx_fill = 8'd31;
      cyc(3);
      `CHK(rts_n, 1'b0)
      rx_fill = 8'd32;
      cyc(2);
      `CHK(rts_n, 1'b1)
      rx_fill = 8'd17;
      cyc(2);
      `CHK(rts_n, 1'b1)
      rx_fill = 8'd16;
      cyc(2);
      `CHK(rts_n, 1'b0)
      cts_n = 1'b1;
      cyc(1);
      `CHK(tx_halt, 1'b1)
      cts_n = 1'b0;
      cyc(1);
      `CHK(tx_halt, 1'b0)
   endtask

   task automatic t_ready;
      tx_free = 8'd16;
      rx_fill = 8'd24;
      cyc(2);
      `CHK({tx_ready, rx_ready}, 2'b10)
      tx_free = 8'd15;
      rx_fill = 8'd25;
      cyc(2);
      `CHK({tx_ready, rx_ready}, 2'b01)
      rx_fill = 8'd0;
      rx_timeout = 1'b1;
      i_host.wr(3'h4, 8'h04);
      i_host.rd(3'h7, d);
      `CHK(d, 8'h10)
      i_host.wr(3'h4, 8'h14);
      i_host.rd(3'h7, d);
      `CHK(d, 8'h00)
   endtask

   task automatic t_special;
      i_host.wr(3'h3, 8'hBF);
      i_host.wr(3'h2, 8'hF5);
      i_host.wr(3'h7, 8'h5A);
      i_host.wr(3'h3, 8'h00);
      rx_char = 8'h5A;
      rx_char_valid = 1'b1;
      cyc(1);
      rx_char_valid = 1'b0;
      `CHK(special_match, 1'b1)
      cyc(1);
      `CHK(special_match, 1'b0)
      // Identification read: fifo control bit 0 mirrored, flag set, then cleared
      i_host.rd(3'h2, d);
      `CHK(d, 8'hD1)
      i_host.rd(3'h2, d);
      `CHK(d, 8'hC1)
   endtask

   task automatic t_half_duplex;
      i_host.wr(3'h3, 8'h80);
      i_host.wr(3'h2, 8'h04);
      tx_pending = 1'b0;
      cyc(2);
      `CHK(dtr_n, 1'b0)
      tx_pending = 1'b1;
      cyc(2);
      `CHK(dtr_n, 1'b1)
   endtask

   // ****************************************
   // Sequence and verdict
   // ****************************************
   task automatic end_of_test;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      #1 resetn = 1'b1;
      cyc(2);
      t_reset();
      t_gate();
      t_div();
      t_thr();
      t_flow();
      t_ready();
      t_special();
      t_half_duplex();
      end_of_test();
   end

   initial begin
      #100us;
      failures++;
      end_of_test();
   end
endmodule

`default_nettype wire

// *** ufcr_flow.sv ***
// Trigger-level selection, automatic RTS hysteresis and FIFO ready status.
// Assumes fill counts from the UART datapath on the same clock.
`default_nettype none

module ufcr_flow (
   input wire logic clk,
   input wire logic rst_n,
   input wire ufcr_pkg::ufcr_fifo_t fifo,
   input wire ufcr_pkg::ufcr_flow_cfg_t cfg,
   output ufcr_pkg::ufcr_flow_st_t st
);

   // ****************************************
   // Level arithmetic
   // ****************************************
   function automatic logic [7:0] nib_level(input logic [3:0] nib);
      nib_level = {1'b0, nib, 3'h0};
   endfunction

   function automatic logic [7:0] fcr_tx(input logic [1:0] sel);
      case (sel)
         2'h0: fcr_tx = ufcr_pkg::FCR_TX_LEVEL0;
         2'h1: fcr_tx = ufcr_pkg::FCR_TX_LEVEL1;
         2'h2: fcr_tx = ufcr_pkg::FCR_TX_LEVEL2;
         default: fcr_tx = ufcr_pkg::FCR_TX_LEVEL3;
      endcase
   endfunction

   function automatic logic [7:0] fcr_rx(input logic [1:0] sel);
      case (sel)
         2'h0: fcr_rx = ufcr_pkg::FCR_RX_LEVEL0;
         2'h1: fcr_rx = ufcr_pkg::FCR_RX_LEVEL1;
         2'h2: fcr_rx = ufcr_pkg::FCR_RX_LEVEL2;
         default: fcr_rx = ufcr_pkg::FCR_RX_LEVEL3;
      endcase
   endfunction

   logic [7:0] tx_trig;
   logic [7:0] rx_trig;
   logic [7:0] halt_lvl;
   logic [7:0] restore_lvl;
   logic rts_halt;

   // Zero nibble falls back to fifo control selection
   assign tx_trig = (cfg.fifo_trigger_levels[3:0] == 4'h0) ? fcr_tx(cfg.fifo_control[5:4])
                    : nib_level(cfg.fifo_trigger_levels[3:0]);
   assign rx_trig = (cfg.fifo_trigger_levels[7:4] == 4'h0) ? fcr_rx(cfg.fifo_control[7:6])
                    : nib_level(cfg.fifo_trigger_levels[7:4]);
   assign halt_lvl = nib_level(cfg.flow_thresholds[3:0]);
   assign restore_lvl = nib_level(cfg.flow_thresholds[7:4]);

   // ****************************************
   // Automatic RTS hysteresis
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rts_halt <= 1'b0;
      end else if (!cfg.auto_rts) begin
         rts_halt <= 1'b0;
      end else if (fifo.rx_fill >= halt_lvl) begin
         rts_halt <= 1'b1;
      end else if (fifo.rx_fill <= restore_lvl) begin
         rts_halt <= 1'b0;
      end
   end

   always_comb begin
      st.tx_trigger = tx_trig;
      st.rx_trigger = rx_trig;
      st.rts_halt = rts_halt;
      st.tx_ready = (fifo.tx_free >= tx_trig);
      st.rx_ready = (fifo.rx_fill > rx_trig) | fifo.rx_timeout;
   end

   AST_RTS_HALT_AT_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
      cfg.auto_rts && $past(cfg.auto_rts) && fifo.rx_fill >= halt_lvl && $stable(halt_lvl)
      |=> rts_halt)
      else $error("RTS halt not raised at halt level");

   AST_RTS_RESTORE: assert property (@(posedge clk) disable iff (!rst_n)
      fifo.rx_fill <= restore_lvl && fifo.rx_fill < halt_lvl |=> !rts_halt)
      else $error("RTS halt not released at restore level");

endmodule

`default_nettype wire

// *** ufcr_host.sv ***
// Host processor model on the parallel register bus.
// Assumes the bench clock; requests start 1 ns after a rising edge.
`default_nettype none

module ufcr_host (
   input wire logic clk,
   output logic cs_n,
   output logic wr_n,
   output logic rd_n,
   output logic [2:0] addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // Bus cycles
   // ****************************************
   initial begin
      {cs_n, wr_n, rd_n, addr, wdata} = {3'h7, 3'h0, 8'h00};
   end

   // Released lines show the inverse of the last value
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      {cs_n, wr_n, rd_n, addr, wdata} = {3'h1, a, d};
      @(posedge clk) #1;
      {cs_n, wr_n, rd_n, addr, wdata} = {3'h7, ~a, ~d};
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk) #1;
      {cs_n, wr_n, rd_n, addr} = {3'h2, a};
      @(posedge clk) #1;
      {cs_n, wr_n, rd_n, addr} = {3'h7, ~a};
      @(posedge clk) #1;
      d = rdata;
   endtask
endmodule

`default_nettype wire

// *** ufcr_pkg.sv ***
// Constants, register map and carrier types of the UART configuration block.
// Assumes a synchronous host bus and UART datapath on the same clock.
`default_nettype none

package ufcr_pkg;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
   localparam logic [2:0] ADDR_INT_ENABLE = 3'h1;
   localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
   localparam logic [2:0] ADDR_FIFO_CTRL = 3'h2;
   localparam logic [2:0] ADDR_ENH_FEATURE = 3'h2;
   localparam logic [2:0] ADDR_ALT_FUNC = 3'h2;
   localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
   localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
   localparam logic [2:0] ADDR_DIV_FRACTION = 3'h4;
   localparam logic [2:0] ADDR_FLOW_THRESH = 3'h6;
   localparam logic [2:0] ADDR_TRIG_LEVELS = 3'h7;
   localparam logic [2:0] ADDR_FIFO_READY = 3'h7;
   localparam logic [2:0] ADDR_SPECIAL_CHAR = 3'h7;

   // ****************************************
   // Bank selection through line control
   // ****************************************
   localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
   localparam int LCR_DIV_BIT = 7;
   localparam logic [2:0] LCR_ALT_SEL = 3'h4;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int EFR_WRITE_GATE = 4;
   localparam int EFR_SPECIAL_DET = 5;
   localparam int EFR_AUTO_RTS = 6;
   localparam int EFR_AUTO_CTS = 7;
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_READY_EN = 2;
   localparam int MCR_LOOPBACK = 4;
   localparam int MCR_THRESH_ACCESS = 6;
   localparam int IER_SLEEP = 4;
   localparam int IIR_SPECIAL = 4;
   localparam int DLF_BY8 = 7;
   localparam int AFR_HALF_DUPLEX = 2;
   localparam int FRDY_TX = 0;
   localparam int FRDY_RX = 4;
   localparam logic [7:0] IER_GATED_MASK = 8'hF0;
   localparam logic [7:0] FCR_GATED_MASK = 8'h30;
   localparam logic [7:0] MCR_GATED_MASK = 8'hE0;

   // ****************************************
   // Reset values and trigger arithmetic
   // ****************************************
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] IIR_RESET = 8'h01;
   localparam int TRIG_STEP_LOG2 = 3;
   localparam logic [7:0] FCR_TX_LEVEL0 = 8'h08;
   localparam logic [7:0] FCR_TX_LEVEL1 = 8'h10;
   localparam logic [7:0] FCR_TX_LEVEL2 = 8'h20;
   localparam logic [7:0] FCR_TX_LEVEL3 = 8'h38;
   localparam logic [7:0] FCR_RX_LEVEL0 = 8'h08;
   localparam logic [7:0] FCR_RX_LEVEL1 = 8'h10;
   localparam logic [7:0] FCR_RX_LEVEL2 = 8'h38;
   localparam logic [7:0] FCR_RX_LEVEL3 = 8'h3C;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [7:0] rx_fill;
      logic [7:0] tx_free;
      logic rx_timeout;
   } ufcr_fifo_t;

   typedef struct packed {
      logic [7:0] flow_thresholds;
      logic [7:0] fifo_trigger_levels;
      logic [7:0] fifo_control;
      logic auto_rts;
   } ufcr_flow_cfg_t;

   typedef struct packed {
      logic [7:0] tx_trigger;
      logic [7:0] rx_trigger;
      logic rts_halt;
      logic tx_ready;
      logic rx_ready;
   } ufcr_flow_st_t;

endpackage

`default_nettype wire

// *** ufcr_top.sv ***
// Configuration and status registers of a UART with 128-byte FIFOs.
// Assumes host strobes and UART datapath signals synchronous to CLK_SYS.
`default_nettype none

// What this block does
// - Low four feature bits select software flow
// - Feature bit 4 gates extended control writes
// - Special character match stores and flags
// - Auto RTS halts at threshold, restores lower
// - Auto CTS halts transmit while CTS high
// - Sixteen bit divisor from high, low latches
// - Fraction latch adds value over 64
// - Fraction bit 7 picks oversample 16/8
// - Threshold nibble counts steps of eight
// - Threshold writes need feature4 and modem6
// - Trigger nibbles: transmit low, receive high
// - Zero trigger nibble uses fifo control levels
// - Ready bit 0: enough transmit spaces
// - Ready bit 4: receive above trigger/timeout
// - Ready register at 111 when enabled, no loopback, threshold access closed
// - Alternate function at 010 with select 100
// - Half duplex mode holds DTR during transmit
// - Modem bit 6 with feature bit 4 opens threshold register access
module ufcr_top (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CS_N,
   input wire logic WR_N,
   input wire logic RD_N,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   output logic [7:0] RDATA,
   input wire logic [7:0] RX_FILL,
   input wire logic [7:0] TX_FREE,
   input wire logic RX_TIMEOUT,
   input wire logic RX_CHAR_VALID,
   input wire logic [7:0] RX_CHAR,
   input wire logic TX_PENDING,
   input wire logic CTS_N,
   output logic RTS_N,
   output logic DTR_N,
   output logic TX_HALT,
   output logic SPECIAL_MATCH,
   output logic [3:0] SW_FLOW_SEL,
   output logic [15:0] DIVISOR,
   output logic [5:0] DIVISOR_FRAC,
   output logic OVERSAMPLE_BY8,
   output logic [7:0] TX_TRIGGER,
   output logic [7:0] RX_TRIGGER,
   output logic TX_READY,
   output logic RX_READY
);

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] line_control;
   logic [7:0] interrupt_enable;
   logic [7:0] fifo_control;
   logic [7:0] modem_control;
   logic [7:0] enhanced_feature;
   logic [7:0] divisor_low;
   logic [7:0] divisor_high;
   logic [7:0] divisor_fraction;
   logic [7:0] flow_thresholds;
   logic [7:0] fifo_trigger_levels;
   logic [7:0] alternate_function;
   logic [7:0] special_char;
   logic special_flag;
   logic rd_prev;

   // ****************************************
   // Bank decode
   // ****************************************
   logic wr_en;
   logic rd_take;
   logic bank_enh;
   logic bank_div;
   logic bank_alt;
   logic gate_open;
   logic thresh_open;
   logic ready_vis;
   logic sleep_on;

   assign wr_en = !CS_N && !WR_N;
   assign rd_take = !CS_N && !RD_N && !rd_prev;
   assign bank_enh = (line_control == ufcr_pkg::LCR_ENH_KEY);
   assign bank_alt = !bank_enh && (line_control[7:5] == ufcr_pkg::LCR_ALT_SEL);
   assign bank_div = !bank_enh && line_control[ufcr_pkg::LCR_DIV_BIT];
   assign gate_open = enhanced_feature[ufcr_pkg::EFR_WRITE_GATE];
   assign thresh_open = gate_open && modem_control[ufcr_pkg::MCR_THRESH_ACCESS];
   assign ready_vis = modem_control[ufcr_pkg::MCR_READY_EN] && !modem_control[ufcr_pkg::MCR_LOOPBACK];
   assign sleep_on = interrupt_enable[ufcr_pkg::IER_SLEEP];

   // Keeps ungated bits from the bus, gated bits from the old value unless open
   function automatic logic [7:0] gated_merge(input logic [7:0] old_val, input logic [7:0] new_val,
                                              input logic [7:0] mask, input logic open);
      gated_merge = open ? new_val : ((old_val & mask) | (new_val & ~mask));
   endfunction

   logic wr_lcr;
   logic wr_ier;
   logic wr_fcr;
   logic wr_mcr;
   logic wr_efr;
   logic wr_xoff2;
   logic wr_dll;
   logic wr_dlh;
   logic wr_dlf;
   logic wr_afr;
   logic wr_tcr;
   logic wr_tlr;

   always_comb begin
      wr_lcr = wr_en && ADDR == ufcr_pkg::ADDR_LINE_CTRL;
      wr_efr = wr_en && bank_enh && ADDR == ufcr_pkg::ADDR_ENH_FEATURE;
      wr_xoff2 = wr_en && bank_enh && ADDR == ufcr_pkg::ADDR_SPECIAL_CHAR;
      wr_dll = wr_en && bank_div && !sleep_on && ADDR == ufcr_pkg::ADDR_DIV_LOW;
      wr_dlh = wr_en && bank_div && !sleep_on && ADDR == ufcr_pkg::ADDR_DIV_HIGH;
      wr_dlf = wr_en && bank_div && !sleep_on && ADDR == ufcr_pkg::ADDR_DIV_FRACTION;
      wr_afr = wr_en && bank_alt && ADDR == ufcr_pkg::ADDR_ALT_FUNC;
      wr_ier = wr_en && !bank_enh && !bank_div && ADDR == ufcr_pkg::ADDR_INT_ENABLE;
      wr_fcr = wr_en && !bank_enh && !bank_div && ADDR == ufcr_pkg::ADDR_FIFO_CTRL;
      wr_mcr = wr_en && !bank_enh && !bank_div && ADDR == ufcr_pkg::ADDR_MODEM_CTRL;
      wr_tcr = wr_en && !bank_enh && !bank_div && thresh_open && ADDR == ufcr_pkg::ADDR_FLOW_THRESH;
      wr_tlr = wr_en && !bank_enh && !bank_div && thresh_open && ADDR == ufcr_pkg::ADDR_TRIG_LEVELS;
   end

   // ****************************************
   // Register writes
   // ****************************************
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         line_control <= ufcr_pkg::REG_RESET;
         enhanced_feature <= ufcr_pkg::REG_RESET;
         special_char <= ufcr_pkg::REG_RESET;
         alternate_function <= ufcr_pkg::REG_RESET;
      end else begin
         if (wr_lcr) begin
            line_control <= WDATA;
         end
         if (wr_efr) begin
            enhanced_feature <= WDATA;
         end
         if (wr_xoff2) begin
            special_char <= WDATA;
         end
         if (wr_afr) begin
            alternate_function <= WDATA;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         interrupt_enable <= ufcr_pkg::REG_RESET;
         fifo_control <= ufcr_pkg::REG_RESET;
         modem_control <= ufcr_pkg::REG_RESET;
      end else begin
         if (wr_ier) begin
            interrupt_enable <= gated_merge(interrupt_enable, WDATA, ufcr_pkg::IER_GATED_MASK, gate_open);
         end
         if (wr_fcr) begin
            fifo_control <= gated_merge(fifo_control, WDATA, ufcr_pkg::FCR_GATED_MASK, gate_open);
         end
         if (wr_mcr) begin
            modem_control <= gated_merge(modem_control, WDATA, ufcr_pkg::MCR_GATED_MASK, gate_open);
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         divisor_low <= ufcr_pkg::REG_RESET;
         divisor_high <= ufcr_pkg::REG_RESET;
         divisor_fraction <= ufcr_pkg::REG_RESET;
      end else begin
         if (wr_dll) begin
            divisor_low <= WDATA;
         end
         if (wr_dlh) begin
            divisor_high <= WDATA;
         end
         if (wr_dlf) begin
            divisor_fraction <= WDATA;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         flow_thresholds <= ufcr_pkg::REG_RESET;
         fifo_trigger_levels <= ufcr_pkg::REG_RESET;
      end else begin
         if (wr_tcr) begin
            flow_thresholds <= WDATA;
         end
         if (wr_tlr) begin
            fifo_trigger_levels <= WDATA;
         end
      end
   end

   // ****************************************
   // Special character detect
   // ****************************************
   logic char_hit;

   assign char_hit = enhanced_feature[ufcr_pkg::EFR_SPECIAL_DET] && RX_CHAR_VALID && RX_CHAR == special_char;

   // Set wins over the read-clear of the identification register
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         special_flag <= 1'b0;
      end else if (char_hit) begin
         special_flag <= 1'b1;
      end else if (rd_take && !bank_enh && !bank_div && ADDR == ufcr_pkg::ADDR_FIFO_CTRL) begin
         special_flag <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         SPECIAL_MATCH <= 1'b0;
      end else begin
         SPECIAL_MATCH <= char_hit;
      end
   end

   // ****************************************
   // Flow control and trigger status
   // ****************************************
   ufcr_pkg::ufcr_fifo_t fifo_st;
   ufcr_pkg::ufcr_flow_cfg_t flow_cfg;
   ufcr_pkg::ufcr_flow_st_t flow_st;

   always_comb begin
      fifo_st.rx_fill = RX_FILL;
      fifo_st.tx_free = TX_FREE;
      fifo_st.rx_timeout = RX_TIMEOUT;
      flow_cfg.flow_thresholds = flow_thresholds;
      flow_cfg.fifo_trigger_levels = fifo_trigger_levels;
      flow_cfg.fifo_control = fifo_control;
      flow_cfg.auto_rts = enhanced_feature[ufcr_pkg::EFR_AUTO_RTS];
   end

   ufcr_flow u_flow (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .fifo(fifo_st),
      .cfg(flow_cfg),
      .st(flow_st)
   );

   logic [7:0] ready_byte;

   always_comb begin
      ready_byte = 8'h00;
      ready_byte[ufcr_pkg::FRDY_TX] = flow_st.tx_ready;
      ready_byte[ufcr_pkg::FRDY_RX] = flow_st.rx_ready;
   end

   // ****************************************
   // Pin and configuration outputs
   // ****************************************
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         RTS_N <= 1'b1;
         DTR_N <= 1'b1;
         TX_HALT <= 1'b0;
      end else begin
         RTS_N <= enhanced_feature[ufcr_pkg::EFR_AUTO_RTS] ? flow_st.rts_halt
                  : !modem_control[ufcr_pkg::MCR_RTS];
         DTR_N <= alternate_function[ufcr_pkg::AFR_HALF_DUPLEX] ? TX_PENDING
                  : !modem_control[ufcr_pkg::MCR_DTR];
         TX_HALT <= enhanced_feature[ufcr_pkg::EFR_AUTO_CTS] && CTS_N;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         SW_FLOW_SEL <= 4'h0;
         DIVISOR <= 16'h0000;
         DIVISOR_FRAC <= 6'h00;
         OVERSAMPLE_BY8 <= 1'b0;
         TX_TRIGGER <= 8'h00;
         RX_TRIGGER <= 8'h00;
         TX_READY <= 1'b0;
         RX_READY <= 1'b0;
      end else begin
         SW_FLOW_SEL <= enhanced_feature[3:0];
         DIVISOR <= {divisor_high, divisor_low};
         DIVISOR_FRAC <= divisor_fraction[5:0];
         OVERSAMPLE_BY8 <= divisor_fraction[ufcr_pkg::DLF_BY8];
         TX_TRIGGER <= flow_st.tx_trigger;
         RX_TRIGGER <= flow_st.rx_trigger;
         TX_READY <= flow_st.tx_ready;
         RX_READY <= flow_st.rx_ready;
      end
   end

   // ****************************************
   // Register reads
   // ****************************************
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (ADDR == ufcr_pkg::ADDR_LINE_CTRL) begin
         next_rdata = line_control;
      end else if (bank_enh) begin
         case (ADDR)
            ufcr_pkg::ADDR_ENH_FEATURE: next_rdata = enhanced_feature;
            ufcr_pkg::ADDR_SPECIAL_CHAR: next_rdata = special_char;
            default: next_rdata = 8'h00;
         endcase
      end else if (bank_div) begin
         case (ADDR)
            ufcr_pkg::ADDR_DIV_LOW: next_rdata = divisor_low;
            ufcr_pkg::ADDR_DIV_HIGH: next_rdata = divisor_high;
            ufcr_pkg::ADDR_DIV_FRACTION: next_rdata = divisor_fraction;
            ufcr_pkg::ADDR_ALT_FUNC: next_rdata = bank_alt ? alternate_function : 8'h00;
            default: next_rdata = 8'h00;
         endcase
      end else begin
         case (ADDR)
            ufcr_pkg::ADDR_INT_ENABLE: next_rdata = interrupt_enable;
            ufcr_pkg::ADDR_FIFO_CTRL: next_rdata = {{2{fifo_control[0]}}, 1'b0, special_flag, 4'h1};
            ufcr_pkg::ADDR_MODEM_CTRL: next_rdata = modem_control;
            ufcr_pkg::ADDR_FLOW_THRESH: next_rdata = thresh_open ? flow_thresholds : 8'h00;
            ufcr_pkg::ADDR_TRIG_LEVELS: next_rdata = thresh_open ? fifo_trigger_levels
                                                     : (ready_vis ? ready_byte : 8'h00);
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= 8'h00;
         rd_prev <= 1'b0;
      end else begin
         rd_prev <= !CS_N && !RD_N;
         if (!CS_N && !RD_N) begin
            RDATA <= next_rdata;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence seq_gate_closed_mcr;
      wr_mcr && !gate_open;
   endsequence

   sequence seq_match;
      char_hit;
   endsequence

   AST_GATED_MCR_HELD: assert property (seq_gate_closed_mcr |=>
      modem_control[7:5] == $past(modem_control[7:5]))
      else $error("Gated modem bits changed while closed");

   AST_THRESH_BLOCKED: assert property (wr_en && !thresh_open |=> $stable(flow_thresholds))
      else $error("Threshold written without access");

   AST_SPECIAL_FLAG: assert property (seq_match |=> special_flag && SPECIAL_MATCH)
      else $error("Special character not flagged");

   AST_CTS_HALT: assert property (enhanced_feature[7] && CTS_N |=> TX_HALT)
      else $error("Transmit not halted on CTS high");

   AST_DIVISOR: assert property (wr_dlh |=> ##1 DIVISOR[15:8] == $past(WDATA, 2))
      else $error("Divisor high byte wrong");

   AST_FRACTION: assert property (wr_dlf |=> ##1 DIVISOR_FRAC == $past(WDATA[5:0], 2)
      && OVERSAMPLE_BY8 == $past(WDATA[7], 2))
      else $error("Fraction or oversample wrong");

   AST_READY_READ: assert property (!CS_N && !RD_N && ADDR == 3'h7 && !bank_enh && !bank_div && !thresh_open
      && ready_vis |=> RDATA[7:5] == 3'h0 && RDATA[3:1] == 3'h0 && RDATA[0] == $past(flow_st.tx_ready))
      else $error("Ready register read wrong");

   AST_DTR_HALF_DUPLEX: assert property (alternate_function[2] && TX_PENDING |=> DTR_N)
      else $error("Driver enable dropped with data pending");

endmodule

`default_nettype wire
